// file: design/dhi_map.vh
// constants for the display host interface
`ifndef DHI_MAP_VH
`define DHI_MAP_VH
// mode select codes {mode_sel_2,mode_sel_1,mode_sel_0}
`define DHI_MODE_PAR 3'h0
`define DHI_MODE_SER3 3'h5
`define DHI_MODE_SER4 3'h6
`define DHI_MODE_SER2L 3'h7
// idle levels of {mode, cs_n, dc, wr, rd_n, sdi, line sync, dot clock}
`define DHI_PIN_IDLE 10'h058
// parallel and serial word widths
`define DHI_WORD_W 8
`define DHI_BIT_CNT_W 4
`define DHI_SER3_BITS 4'h9
`define DHI_SER4_BITS 4'h8
`define DHI_SER2L_STEPS 4'h4
// pixel width
`define DHI_PIX_W 18
`endif

// file: design/dhi_sync3.v
// three flip-flop synchroniser with agreement qualified output
`default_nettype none
module dhi_sync3 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // asynchronous input and synchronised level
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    wire [W-1:0] nxt_sync;
    genvar g;
    // reset to the pins' idle levels so no false edge follows reset
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // a change counts once stages two and three agree
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_g
            assign nxt_sync[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : sync_o[g];
        end
    endgenerate
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_o <= RST_VAL;
        end else begin
            sync_o <= nxt_sync;
        end
    end
endmodule
`default_nettype wire

// file: design/dhi_host_port.v
// host port of the display: parallel bus, serial link and pixel stream
// Functional notes
// [R1] parallel and serial transfers only while chip select is low
// [R2] data/command select high: word is display data or parameter
// [R3] data/command select low: word is a command code
// [R4] parallel writes are delivered by the write strobe
// [R5] parallel reads use the read strobe; host latches on its rising edge
// [R6] 4-line serial: write strobe pin carries data/command select
// [R7] two-lane serial: write strobe pin carries second data lane
// [R8] serial input data sampled on serial clock rising edge
// [R9] serial modes: data/command select pin is the serial clock
// [R10] serial read data changes on serial clock falling edge
// [R11] host sets interface type with three static mode pins
// [R12] pixel stream needs a serial mode for commands
// [R13] frame sync marks frame start
// [R14] line sync marks line start
// [R15] pixels accepted only while data enable is high
// [R16] pixel transfers timed by the host dot clock
// [R17] host applies hardware reset before use
`default_nettype none
`include "dhi_map.vh"
module dhi_host_port #(
    parameter WORD_W = `DHI_WORD_W,
    parameter PIX_W = `DHI_PIX_W
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // mode select pins
    input wire mode_sel_2_i,
    input wire mode_sel_1_i,
    input wire mode_sel_0_i,
    // host control pins
    input wire chip_sel_n_i,
    input wire data_command_sel_i,
    input wire serial_dc_or_lane2_i,
    input wire rd_strobe_n_i,
    input wire serial_data_in_i,
    // parallel_data_bus as three signals
    input wire [WORD_W-1:0] parallel_data_bus_i,
    output reg [WORD_W-1:0] parallel_data_bus_o,
    output wire parallel_data_bus_oe_n_o,
    output reg serial_data_out_o,
    // pixel stream pins
    input wire frame_sync_i,
    input wire line_sync_i,
    input wire data_enable_i,
    input wire pixel_clock_i,
    input wire [PIX_W-1:0] pixel_data_i,
    // core side: received words
    output reg word_valid_o,
    output reg word_is_data_o,
    output reg [WORD_W-1:0] word_o,
    // core side: read data to return
    input wire [WORD_W-1:0] read_data_i,
    output reg read_taken_o,
    // core side: pixels
    output reg pixel_valid_o,
    output reg [PIX_W-1:0] pixel_o,
    output reg frame_start_o,
    output reg line_start_o
);
    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    localparam NS = 10 + WORD_W;
    wire [NS-1:0] s;
    dhi_sync3 #(.W(NS), .RST_VAL({`DHI_PIN_IDLE, {WORD_W{1'b0}}})) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({mode_sel_2_i, mode_sel_1_i, mode_sel_0_i, chip_sel_n_i,
                  data_command_sel_i, serial_dc_or_lane2_i, rd_strobe_n_i,
                  serial_data_in_i, line_sync_i, pixel_clock_i,
                  parallel_data_bus_i}),
        .sync_o(s)
    );
    wire [2:0] mode = s[NS-1:NS-3];
    wire cs_n = s[NS-4];
    wire dc_pin = s[NS-5];
    wire wr_pin = s[NS-6];
    wire rd_n = s[NS-7];
    wire sdi = s[NS-8];
    wire hs = s[NS-9];
    wire pclk = s[NS-10];
    wire [WORD_W-1:0] db = s[WORD_W-1:0];
    // frame sync, data enable and pixel data synchronised separately so the pixel bus stays apart
    wire [PIX_W+1:0] ps;
    dhi_sync3 #(.W(PIX_W + 2)) u_psync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({frame_sync_i, data_enable_i, pixel_data_i}),
        .sync_o(ps)
    );
    // ***************************************************************
    // edge detection
    // ***************************************************************
    reg wr_d_ff, rd_d_ff, sck_d_ff, pclk_d_ff, vs_d_ff, hs_d_ff;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_d_ff <= 1'b1;
            rd_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
            pclk_d_ff <= 1'b0;
            vs_d_ff <= 1'b0;
            hs_d_ff <= 1'b0;
        end else begin
            wr_d_ff <= wr_pin;
            rd_d_ff <= rd_n;
            sck_d_ff <= dc_pin;
            pclk_d_ff <= pclk;
            vs_d_ff <= ps[PIX_W+1];
            hs_d_ff <= hs;
        end
    end
    wire is_par = (mode == `DHI_MODE_PAR); // [R11]
    wire is_ser = (mode == `DHI_MODE_SER3) || (mode == `DHI_MODE_SER4) ||
                  (mode == `DHI_MODE_SER2L);
    wire sel = ~cs_n; // [R1]
    wire wr_rise = wr_pin & ~wr_d_ff;
    wire rd_fall = ~rd_n & rd_d_ff;
    wire sck_rise = dc_pin & ~sck_d_ff; // [R9]
    wire sck_fall = ~dc_pin & sck_d_ff;
    // ***************************************************************
    // parallel port
    // ***************************************************************
    reg rd_act_ff;
    assign parallel_data_bus_oe_n_o = ~rd_act_ff;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_act_ff <= 1'b0;
            parallel_data_bus_o <= {WORD_W{1'b0}};
        end else if (is_par && sel && rd_fall) begin
            rd_act_ff <= 1'b1; // [R5]
            parallel_data_bus_o <= read_data_i;
        end else if (rd_n || !sel || !is_par) begin
            rd_act_ff <= 1'b0; // held until host latches on rising edge [R5]
        end
    end
    // ***************************************************************
    // serial port
    // ***************************************************************
    reg [WORD_W-1:0] sh_ff;
    reg [`DHI_BIT_CNT_W-1:0] cnt_ff;
    reg dc_ser_ff;
    reg [WORD_W-1:0] tx_ff;
    wire [`DHI_BIT_CNT_W-1:0] last =
        (mode == `DHI_MODE_SER3) ? `DHI_SER3_BITS :
        (mode == `DHI_MODE_SER2L) ? `DHI_SER2L_STEPS : `DHI_SER4_BITS;
    wire [`DHI_BIT_CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;
    wire ser_done = sck_rise && (cnt_inc == last);
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_ff <= {WORD_W{1'b0}};
            cnt_ff <= {`DHI_BIT_CNT_W{1'b0}};
            dc_ser_ff <= 1'b0;
        end else if (!is_ser || !sel) begin
            cnt_ff <= {`DHI_BIT_CNT_W{1'b0}}; // [R1]
        end else if (sck_rise) begin // [R8]
            cnt_ff <= ser_done ? {`DHI_BIT_CNT_W{1'b0}} : cnt_inc;
            if (mode == `DHI_MODE_SER3 && cnt_ff == {`DHI_BIT_CNT_W{1'b0}}) begin
                dc_ser_ff <= sdi; // leading d/c bit in 3-line
            end else if (mode == `DHI_MODE_SER2L) begin
                sh_ff <= {sh_ff[WORD_W-3:0], sdi, wr_pin}; // [R7]
            end else begin
                sh_ff <= {sh_ff[WORD_W-2:0], sdi};
            end
            if (mode == `DHI_MODE_SER4) begin
                dc_ser_ff <= wr_pin; // [R6]
            end
        end
    end
    // serial read data shifts out on falling edges
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_ff <= {WORD_W{1'b0}};
            serial_data_out_o <= 1'b0;
        end else if (!is_ser || !sel) begin
            tx_ff <= read_data_i;
        end else if (sck_fall) begin // [R10]
            serial_data_out_o <= tx_ff[WORD_W-1];
            tx_ff <= {tx_ff[WORD_W-2:0], 1'b0};
        end
    end
    // ***************************************************************
    // word output and read acknowledge
    // ***************************************************************
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_valid_o <= 1'b0;
            word_is_data_o <= 1'b0;
            word_o <= {WORD_W{1'b0}};
            read_taken_o <= 1'b0;
        end else begin
            word_valid_o <= 1'b0;
            read_taken_o <= is_par && sel && rd_fall;
            if (is_par && sel && wr_rise) begin // [R4]
                word_valid_o <= 1'b1;
                word_is_data_o <= dc_pin; // [R2] [R3]
                word_o <= db;
            end else if (is_ser && sel && ser_done) begin
                word_valid_o <= 1'b1;
                word_is_data_o <= (mode == `DHI_MODE_SER4) ? wr_pin : dc_ser_ff; // [R2] [R3]
                word_o <= (mode == `DHI_MODE_SER2L) ? {sh_ff[WORD_W-3:0], sdi, wr_pin}
                        : (mode == `DHI_MODE_SER3) ? {sh_ff[WORD_W-2:0], sdi}
                        : {sh_ff[WORD_W-2:0], sdi};
            end
        end
    end
    // ***************************************************************
    // pixel stream
    // ***************************************************************
    wire pclk_rise = pclk & ~pclk_d_ff; // [R16]
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pixel_valid_o <= 1'b0;
            pixel_o <= {PIX_W{1'b0}};
            frame_start_o <= 1'b0;
            line_start_o <= 1'b0;
        end else begin
            frame_start_o <= ps[PIX_W+1] & ~vs_d_ff; // [R13]
            line_start_o <= hs & ~hs_d_ff; // [R14]
            pixel_valid_o <= 1'b0;
            if (is_ser && pclk_rise && ps[PIX_W]) begin // [R12] [R15]
                pixel_valid_o <= 1'b1;
                pixel_o <= ps[PIX_W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// file: test/dhi_port_sva.sv
// assertions on the display host port
`default_nettype none
module dhi_port_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic mode_sel_2_i,
    input wire logic chip_sel_n_i,
    input wire logic rd_strobe_n_i,
    input wire logic data_enable_i,
    // outputs
    input wire logic parallel_data_bus_oe_n_o,
    input wire logic word_valid_o,
    input wire logic [7:0] word_o,
    input wire logic read_taken_o,
    input wire logic pixel_valid_o,
    input wire logic frame_start_o,
    input wire logic line_start_o
);
    logic [3:0] cs_hi_ff, rd_hi_ff, de_lo_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since each pin was last active
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {cs_hi_ff, rd_hi_ff, de_lo_ff} <= 12'h000;
        end else begin
            cs_hi_ff <= chip_sel_n_i ? cs_hi_ff + {3'h0, cs_hi_ff != 4'hf} : 4'h0;
            rd_hi_ff <= rd_strobe_n_i ? rd_hi_ff + {3'h0, rd_hi_ff != 4'hf} : 4'h0;
            de_lo_ff <= !data_enable_i ? de_lo_ff + {3'h0, de_lo_ff != 4'hf} : 4'h0;
        end
    end
    sequence s_word_pulse;
        word_valid_o ##1 !word_valid_o;
    endsequence
    sequence s_read_start;
        rd_hi_ff == 4'h0 ##1 !read_taken_o;
    endsequence
    a_cs_gates_word: assert property (word_valid_o |-> cs_hi_ff < 4'ha)
        else $error("word taken with chip select high");
    a_word_pulse: assert property (word_valid_o |-> s_word_pulse)
        else $error("word valid longer than one cycle");
    a_word_holds: assert property ($changed(word_o) |-> word_valid_o)
        else $error("word changed without valid");
    a_bus_on_read: assert property (!parallel_data_bus_oe_n_o |-> !mode_sel_2_i && rd_hi_ff < 4'h8)
        else $error("bus driven outside a parallel read");
    a_read_taken: assert property (read_taken_o |-> s_read_start)
        else $error("read taken without read strobe");
    a_pix_enable: assert property (pixel_valid_o |-> de_lo_ff < 4'h8 && mode_sel_2_i)
        else $error("pixel taken without data enable");
    a_frame_pulse: assert property (frame_start_o |=> !frame_start_o)
        else $error("frame start longer than one cycle");
    a_line_pulse: assert property (line_start_o |=> !line_start_o)
        else $error("line start longer than one cycle");
endmodule
bind dhi_host_port dhi_port_sva u_sva (
    .clk_i, .rst_i, .mode_sel_2_i, .chip_sel_n_i, .rd_strobe_n_i, .data_enable_i,
    .parallel_data_bus_oe_n_o, .word_valid_o, .word_o, .read_taken_o, .pixel_valid_o,
    .frame_start_o, .line_start_o
);
`default_nettype wire

// file: test/dhi_host_model.sv
// host model driving the display host port pins
`default_nettype none
module dhi_host_model (
    // clock, resolved bus and serial read data
    input wire logic clk_i,
    input wire logic [7:0] bus_i,
    input wire logic sdo_i,
    // pins: mode, {cs_n, dc_or_clk, wr, rd_n, sdi}, bus, {fs, ls, de, pclk}, pixel
    output logic [2:0] mode_o = 3'h0,
    output logic [4:0] ctl_o,
    output logic [7:0] bus_o = 8'h00,
    output logic [3:0] pctl_o,
    output logic [17:0] pix_o = 18'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_n = 1'b1, dc_clk = 1'b0, wr = 1'b1, rd_n = 1'b1, sdi = 1'b0;
    logic fs = 1'b0, ls = 1'b0, de = 1'b0, pclk = 1'b0;
    assign ctl_o = {cs_n, dc_clk, wr, rd_n, sdi};
    assign pctl_o = {fs, ls, de, pclk};
    // half of the 800 ns link period
    task automatic hp();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic tick();
        hp();
        pclk = 1'b1;
        hp();
        pclk = 1'b0;
    endtask
    task automatic par_wr(input logic cs_v, input logic dc_v, input logic [7:0] d);
        {cs_n, dc_clk, wr, bus_o} = {cs_v, dc_v, 1'b0, d};
        hp();
        wr = 1'b1;
        hp();
        {cs_n, bus_o} = {1'b1, ~d};
        hp();
    endtask
    task automatic par_rd(output logic [7:0] d);
        {cs_n, dc_clk, rd_n, bus_o} = {3'b010, ~bus_o};
        hp();
        hp();
        d = bus_i;
        rd_n = 1'b1;
        hp();
        cs_n = 1'b1;
        hp();
    endtask
    task automatic ser_wr(input logic [2:0] m, input logic dc_v, input logic [7:0] d);
        logic [8:0] sh;
        int n;
        sh = {dc_v, d};
        n = (m == 3'h5) ? 9 : (m == 3'h7) ? 4 : 8;
        {mode_o, dc_clk} = {m, 1'b0};
        hp();
        {cs_n, wr} = {1'b0, dc_v};
        hp();
        for (int i = 0; i < n; i++) begin
            if (m == 3'h7) {sdi, wr} = {sh[7 - 2 * i], sh[6 - 2 * i]};
            else sdi = sh[n - 1 - i];
            hp();
            dc_clk = 1'b1;
            hp();
            dc_clk = 1'b0;
        end
        hp();
        {cs_n, sdi} = {1'b1, ~sdi};
        hp();
    endtask
    // 3-line read: sample each bit a half period after the rise that follows its change
    task automatic ser_rd(output logic [7:0] d);
        {mode_o, dc_clk, sdi} = {3'h5, 1'b0, 1'b0};
        hp();
        cs_n = 1'b0;
        hp();
        for (int i = 0; i < 9; i++) begin
            hp();
            dc_clk = 1'b1;
            hp();
            if (i > 0) d = {d[6:0], sdo_i};
            dc_clk = 1'b0;
        end
        hp();
        cs_n = 1'b1;
        hp();
    endtask
    task automatic pix_frame(input logic [17:0] base);
        fs = 1'b1;
        tick();
        {fs, ls} = 2'b01;
        tick();
        ls = 1'b0;
        for (int i = 0; i < 5; i++) begin
            {de, pix_o} = {i < 3, base + 18'(i)};
            tick();
        end
        {de, pix_o} = {1'b0, ~pix_o};
        hp();
    endtask
endmodule
`default_nettype wire

// file: test/dhi_host_port_tb.sv
// self-checking bench of the display host port
`default_nettype none
module dhi_host_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, oe_n, wv, wd, rt, pv, fso, lso, serial_data_out;
    logic [2:0] mode;
    logic [4:0] ctl;
    logic [3:0] pctl;
    logic [7:0] hbus, dbus, rdat, word_o;
    logic [17:0] pix, pixel_o, pix_n = 0, fr_n = 0, ln_n = 0, rt_n = 0;
    logic [8:0] q[$];
    int failures = 0, n_compared = 0;
    wire logic [7:0] bus_w = oe_n ? hbus : dbus;
    dhi_host_model host (.clk_i, .bus_i(bus_w), .sdo_i(serial_data_out), .mode_o(mode), .ctl_o(ctl),
        .bus_o(hbus),
        .pctl_o(pctl), .pix_o(pix));
    dhi_host_port uut (
        .clk_i, .rst_i, .mode_sel_2_i(mode[2]), .mode_sel_1_i(mode[1]), .mode_sel_0_i(mode[0]),
        .chip_sel_n_i(ctl[4]), .data_command_sel_i(ctl[3]), .serial_dc_or_lane2_i(ctl[2]),
        .rd_strobe_n_i(ctl[1]), .serial_data_in_i(ctl[0]), .parallel_data_bus_i(bus_w),
        .parallel_data_bus_o(dbus), .parallel_data_bus_oe_n_o(oe_n), .serial_data_out_o(serial_data_out),
        .frame_sync_i(pctl[3]), .line_sync_i(pctl[2]), .data_enable_i(pctl[1]),
        .pixel_clock_i(pctl[0]), .pixel_data_i(pix), .word_valid_o(wv), .word_is_data_o(wd),
        .word_o, .read_data_i(rdat), .read_taken_o(rt), .pixel_valid_o(pv), .pixel_o,
        .frame_start_o(fso), .line_start_o(lso));
    always @(posedge clk_i) begin
        if (wv === 1'b1) q.push_back({wd, word_o});
        pix_n <= pix_n + 18'(pv === 1'b1);
        fr_n <= fr_n + 18'(fso === 1'b1);
        ln_n <= ln_n + 18'(lso === 1'b1);
        rt_n <= rt_n + 18'(rt === 1'b1);
    end
    task automatic chk(input logic [17:0] s, input logic [17:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic exp_word(input logic [8:0] e, input logic dc_chk);
        logic [8:0] w;
        chk(18'(q.size()), 18'h1);
        w = q.size() > 0 ? q[0] : ~e;
        q.delete();
        chk(18'(w[7:0]), 18'(e[7:0]));
        if (dc_chk) chk(18'(w[8]), 18'(e[8]));
    endtask
    task automatic t_par();
        chk(18'({wv, pv, rt, fso, lso, oe_n}), 18'h1);
        repeat (6) @(negedge clk_i);
        host.par_wr(1'b0, 1'b0, 8'h2a);
        exp_word(9'h02a, 1'b1);
        host.par_wr(1'b0, 1'b1, 8'hc5);
        exp_word(9'h1c5, 1'b1);
        host.par_wr(1'b1, 1'b1, 8'h3c);
        chk(18'(q.size()), 18'h0);
    endtask
    task automatic t_read();
        logic [7:0] d;
        host.par_rd(d);
        chk(18'(d), 18'h96);
        chk(rt_n, 18'h1);
    endtask
    task automatic t_ser();
        logic [2:0] m;
        for (int k = 0; k < 6; k++) begin
            m = 3'h5 + 3'(k / 2);
            host.ser_wr(m, k[0], 8'ha5 ^ 8'(k));
            exp_word({k[0], 8'ha5 ^ 8'(k)}, m != 3'h7);
        end
    endtask
    task automatic t_ser_rd();
        logic [7:0] d;
        host.ser_rd(d);
        chk(18'(d), 18'h96);
        exp_word(9'h000, 1'b1);
    endtask
    task automatic t_pix();
        logic [17:0] p0, f0, l0;
        {p0, f0, l0} = {pix_n, fr_n, ln_n};
        host.pix_frame(18'h25a3c);
        chk(pix_n - p0, 18'h3);
        chk(pixel_o, 18'h25a3e);
        chk(fr_n - f0, 18'h1);
        chk(ln_n - l0, 18'h1);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        {rst_i, rdat} = {1'b1, 8'h96};
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        t_par();
        t_read();
        t_ser();
        t_ser_rd();
        t_pix();
        give_verdict();
    end
endmodule
`default_nettype wire
